// ### hdl/sds_irq.v
// Sticky interrupt status, mask and level interrupt output
`timescale 1ns/10ps
`include "sds_consts.vh"
module sds_irq (
    // Clock and reset
    input  wire       core_clk,
    input  wire       rst_n,
    input  wire       clk_en,
    // Events and software access
    input  wire [5:0] event_pulse,
    input  wire       status_rd,
    input  wire       mask_wr,
    input  wire [5:0] mask_wdata,
    // State
    output reg  [5:0] status_reg,
    output reg  [5:0] mask_reg,
    output reg        irq_reg
);
    reg [5:0] status_next;

    always @* begin
        // A read clears what it returned; a new event in the same cycle survives
        status_next = (status_rd ? 6'h00 : status_reg) | event_pulse;
    end

    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            status_reg <= 6'h00;
            mask_reg   <= `SDS_MASK_RST;
            irq_reg    <= 1'b0;
        end else if (clk_en) begin
            status_reg <= status_next;
            if (mask_wr) begin
                mask_reg <= mask_wdata;
            end
            irq_reg <= |(status_next & (mask_wr ? mask_wdata : mask_reg));
        end
    end
endmodule // sds_irq

// ### hdl/sds_pingpong.v
// Double-buffer load, selection and byte-offset tracking for one direction
`timescale 1ns/10ps
`include "sds_consts.vh"
module sds_pingpong (
    // Clock and reset
    input  wire        core_clk,
    input  wire        rst_n,
    input  wire        clk_en,
    // Control
    input  wire        load_a_set,
    input  wire        load_b_set,
    input  wire        xfer_rst,
    input  wire [12:0] limit,
    // Byte stream
    input  wire        byte_take,
    output reg         ready_reg,
    // State
    output reg         load_a_reg,
    output reg         load_b_reg,
    output reg         cur_b_reg,
    output reg  [12:0] off_a_reg,
    output reg  [12:0] off_b_reg,
    output reg         cur_b_next,
    output reg  [12:0] off_next,
    output reg         done_a,
    output reg         done_b
);
    reg        load_a_next;
    reg        load_b_next;
    reg [12:0] off_a_next;
    reg [12:0] off_b_next;

    always @* begin
        load_a_next = load_a_reg;
        load_b_next = load_b_reg;
        cur_b_next  = cur_b_reg;
        off_a_next  = off_a_reg;
        off_b_next  = off_b_reg;
        done_a      = 1'b0;
        done_b      = 1'b0;
        if (byte_take && ready_reg) begin
            if (!cur_b_reg) begin
                if (off_a_reg == limit) begin
                    off_a_next  = `SDS_OFF_RST; // RL9
                    load_a_next = 1'b0; // RL13
                    done_a      = 1'b1;
                    cur_b_next  = 1'b1;
                end else begin
                    off_a_next = off_a_reg + 13'h0001;
                end
            end else begin
                if (off_b_reg == limit) begin
                    off_b_next  = `SDS_OFF_RST; // RL9
                    load_b_next = 1'b0; // RL13
                    done_b      = 1'b1;
                    cur_b_next  = 1'b0;
                end else begin
                    off_b_next = off_b_reg + 13'h0001;
                end
            end
        end
        // Writing zero to a load bit never reaches here, so it has no effect
        if (load_a_set) begin
            load_a_next = 1'b1; // RL13
        end
        if (load_b_set) begin
            load_b_next = 1'b1; // RL13
        end
        // Idle side hands over to whichever buffer is loaded
        if (cur_b_next ? (!load_b_next && load_a_next) : (!load_a_next && load_b_next)) begin
            cur_b_next = ~cur_b_next;
        end
        if (xfer_rst) begin
            load_a_next = 1'b0;
            load_b_next = 1'b0;
            cur_b_next  = 1'b0;
            off_a_next  = `SDS_OFF_RST;
            off_b_next  = `SDS_OFF_RST;
        end
        off_next = cur_b_next ? off_b_next : off_a_next;
    end

    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            load_a_reg <= 1'b0;
            load_b_reg <= 1'b0;
            cur_b_reg  <= 1'b0;
            off_a_reg  <= `SDS_OFF_RST;
            off_b_reg  <= `SDS_OFF_RST;
            ready_reg  <= 1'b0;
        end else if (clk_en) begin
            load_a_reg <= load_a_next;
            load_b_reg <= load_b_next;
            cur_b_reg  <= cur_b_next;
            off_a_reg  <= off_a_next;
            off_b_reg  <= off_b_next;
            ready_reg  <= load_a_next | load_b_next;
        end
    end
endmodule // sds_pingpong

// ### hdl/sds_top.v
// Serial DMA status and position counters with Avalon-MM register access
//
// Function
// [RL1] A receive overrun is flagged only after both receive buffers were unloaded so the FIFO overran.
// [RL2] Buffer B draining an overrun-marked FIFO sets the buffer-B overrun flag at bit 5.
// [RL3] Buffer A draining an overrun-marked FIFO sets the buffer-A overrun flag at bit 4.
// [RL4] The buffer-B overrun flag clears when buffer B is next loaded or receive DMA is reset.
// [RL5] The buffer-A overrun flag clears when buffer A is next loaded or receive DMA is reset.
// [RL6] A read-only 13-bit offset from zero gives the next byte position in receive buffer A.
// [RL7] A read-only 13-bit offset from zero gives the next byte position in receive buffer B.
// [RL8] A read-only 13-bit offset gives the next byte position in the active transmit buffer.
// [RL9] A buffer that fills and unloads has its byte offset returned to zero.
// [RL10] Software writes the 13-bit receive buffer A start, where buffer A transfers begin.
// [RL11] Four read-only flags show which receive and transmit buffers are the active target.
// [RL12] The receive A start register reads bits 14:13 as one and bit 15 as zero.
// [RL13] Software sets a load bit to start a buffer; it clears on completion; zero writes do nothing.
// [RL14] The receive DMA reset bit resets the receive DMA and clears itself.
`timescale 1ns/10ps
`include "sds_consts.vh"
module sds_top (
    // Clock, enable and reset
    input  wire        core_clk,
    input  wire        rst_n,
    input  wire        clk_en,
    // Avalon-MM slave
    input  wire [16:0] avs_address,
    input  wire        avs_read,
    input  wire        avs_write,
    input  wire [31:0] avs_writedata,
    input  wire [3:0]  avs_byteenable,
    output reg  [31:0] avs_readdata,
    output reg         avs_waitrequest,
    // Receive byte stream from the hardware FIFO
    input  wire        rx_byte_valid,
    input  wire        rx_byte_overrun,
    output wire        rx_byte_ready,
    output reg  [12:0] rx_byte_addr,
    output reg         rx_byte_buf_b,
    // Transmit byte stream towards the hardware FIFO
    input  wire        tx_byte_take,
    output wire        tx_byte_ready,
    output reg  [12:0] tx_byte_offset,
    output reg         tx_byte_buf_b,
    // Interrupt
    output wire        irq
);
    // Word index match on a byte address
    function hit;
        input [16:0] addr;
        input [14:0] idx;
        begin
            hit = (addr[16:2] == idx);
        end
    endfunction

    // Merge the two low byte lanes of a write into a 16-bit register image
    function [15:0] merge16;
        input [15:0] old;
        input [31:0] wdata;
        input [3:0]  be;
        begin
            merge16[7:0]  = be[0] ? wdata[7:0]  : old[7:0];
            merge16[15:8] = be[1] ? wdata[15:8] : old[15:8];
        end
    endfunction

    // Bus handshake and decoded strobes
    wire        acc_go;
    wire        wr_go;
    wire        rd_go;
    reg  [12:0] rx_a_start_address_reg;
    reg  [12:0] buf_limit_reg;
    reg         rx_starved_reg;
    reg         rx_overrun_buf_a_reg;
    reg         rx_overrun_buf_b_reg;
    reg  [15:0] rd_mux;
    reg  [15:0] wr_image;

    // Control writes
    wire        ctrl_wr;
    wire        rx_a_load;
    wire        rx_b_load;
    wire        tx_a_load;
    wire        tx_b_load;
    wire        rx_transfer_reset;
    wire        tx_transfer_reset;

    // Direction state
    wire        rx_load_a_q;
    wire        rx_load_b_q;
    wire        rx_cur_b;
    wire [12:0] rx_a_byte_offset;
    wire [12:0] rx_b_byte_offset;
    wire        rx_cur_b_next;
    wire [12:0] rx_off_next;
    wire        rx_done_a;
    wire        rx_done_b;
    wire        tx_load_a_q;
    wire        tx_load_b_q;
    wire        tx_cur_b;
    wire [12:0] tx_off_a;
    wire [12:0] tx_off_b;
    wire        tx_cur_b_next;
    wire [12:0] tx_off_next;
    wire        tx_done_a;
    wire        tx_done_b;
    wire [12:0] tx_byte_offset_now;

    // Status flags
    wire        rx_active_buf_a;
    wire        rx_active_buf_b;
    wire        tx_active_buf_a;
    wire        tx_active_buf_b;
    wire        rx_take;
    wire        ovr_hit;
    wire        ovr_set_a;
    wire        ovr_set_b;
    wire [15:0] xfer_state;
    wire [5:0]  irq_events;
    wire [5:0]  irq_status;
    wire [5:0]  irq_mask;
    wire        irq_status_rd;
    wire        irq_mask_wr;

    // One wait cycle, then a single cycle with waitrequest low
    assign acc_go = (avs_read | avs_write) & avs_waitrequest;
    assign wr_go  = acc_go & avs_write;
    assign rd_go  = acc_go & avs_read;

    assign ctrl_wr           = wr_go & hit(avs_address, `SDS_IDX_CTRL) & avs_byteenable[0];
    assign rx_a_load         = ctrl_wr & avs_writedata[`SDS_CT_RX_LOAD_A];
    assign rx_b_load         = ctrl_wr & avs_writedata[`SDS_CT_RX_LOAD_B];
    assign tx_a_load         = ctrl_wr & avs_writedata[`SDS_CT_TX_LOAD_A];
    assign tx_b_load         = ctrl_wr & avs_writedata[`SDS_CT_TX_LOAD_B];
    assign rx_transfer_reset = ctrl_wr & avs_writedata[`SDS_CT_RX_RST]; // RL14
    assign tx_transfer_reset = ctrl_wr & avs_writedata[`SDS_CT_TX_RST];

    sds_pingpong u_rx (
        .core_clk   (core_clk),
        .rst_n      (rst_n),
        .clk_en     (clk_en),
        .load_a_set (rx_a_load),
        .load_b_set (rx_b_load),
        .xfer_rst   (rx_transfer_reset),
        .limit      (buf_limit_reg),
        .byte_take  (rx_byte_valid),
        .ready_reg  (rx_byte_ready),
        .load_a_reg (rx_load_a_q),
        .load_b_reg (rx_load_b_q),
        .cur_b_reg  (rx_cur_b),
        .off_a_reg  (rx_a_byte_offset),
        .off_b_reg  (rx_b_byte_offset),
        .cur_b_next (rx_cur_b_next),
        .off_next   (rx_off_next),
        .done_a     (rx_done_a),
        .done_b     (rx_done_b)
    );

    sds_pingpong u_tx (
        .core_clk   (core_clk),
        .rst_n      (rst_n),
        .clk_en     (clk_en),
        .load_a_set (tx_a_load),
        .load_b_set (tx_b_load),
        .xfer_rst   (tx_transfer_reset),
        .limit      (buf_limit_reg),
        .byte_take  (tx_byte_take),
        .ready_reg  (tx_byte_ready),
        .load_a_reg (tx_load_a_q),
        .load_b_reg (tx_load_b_q),
        .cur_b_reg  (tx_cur_b),
        .off_a_reg  (tx_off_a),
        .off_b_reg  (tx_off_b),
        .cur_b_next (tx_cur_b_next),
        .off_next   (tx_off_next),
        .done_a     (tx_done_a),
        .done_b     (tx_done_b)
    );

    // A buffer is the target while loaded and selected
    assign rx_active_buf_a = rx_load_a_q & ~rx_cur_b; // RL11
    assign rx_active_buf_b = rx_load_b_q & rx_cur_b; // RL11
    assign tx_active_buf_a = tx_load_a_q & ~tx_cur_b; // RL11
    assign tx_active_buf_b = tx_load_b_q & tx_cur_b; // RL11
    assign tx_byte_offset_now = tx_cur_b ? tx_off_b : tx_off_a; // RL8

    // Overrun mark only counts on the first byte after a starved period
    assign rx_take   = rx_byte_valid & rx_byte_ready;
    assign ovr_hit   = rx_take & rx_byte_overrun & rx_starved_reg; // RL1
    assign ovr_set_a = ovr_hit & ~rx_cur_b; // RL3
    assign ovr_set_b = ovr_hit & rx_cur_b; // RL2

    assign xfer_state = {10'h000,
                         rx_overrun_buf_b_reg,
                         rx_overrun_buf_a_reg,
                         tx_active_buf_b,
                         tx_active_buf_a,
                         rx_active_buf_b,
                         rx_active_buf_a};

    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rx_starved_reg <= 1'b1;
        end else if (clk_en) begin
            if (rx_transfer_reset) begin
                rx_starved_reg <= 1'b1;
            end else if (!rx_byte_ready) begin
                rx_starved_reg <= 1'b1; // RL1
            end else if (rx_take) begin
                rx_starved_reg <= 1'b0;
            end
        end
    end

    // Overrun flags: DMA reset wins, otherwise a new overrun beats the load clear
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rx_overrun_buf_a_reg <= 1'b0;
            rx_overrun_buf_b_reg <= 1'b0;
        end else if (clk_en) begin
            if (rx_transfer_reset) begin
                rx_overrun_buf_a_reg <= 1'b0; // RL5
                rx_overrun_buf_b_reg <= 1'b0; // RL4
            end else begin
                if (ovr_set_a) begin
                    rx_overrun_buf_a_reg <= 1'b1; // RL3
                end else if (rx_a_load) begin
                    rx_overrun_buf_a_reg <= 1'b0; // RL5
                end
                if (ovr_set_b) begin
                    rx_overrun_buf_b_reg <= 1'b1; // RL2
                end else if (rx_b_load) begin
                    rx_overrun_buf_b_reg <= 1'b0; // RL4
                end
            end
        end
    end

    assign irq_events = {ovr_set_b, ovr_set_a, tx_done_b, tx_done_a, rx_done_b, rx_done_a};
    assign irq_status_rd = rd_go & hit(avs_address, `SDS_IDX_INT_STATUS);
    assign irq_mask_wr   = wr_go & hit(avs_address, `SDS_IDX_INT_MASK) & avs_byteenable[0];

    sds_irq u_irq (
        .core_clk    (core_clk),
        .rst_n       (rst_n),
        .clk_en      (clk_en),
        .event_pulse (irq_events),
        .status_rd   (irq_status_rd),
        .mask_wr     (irq_mask_wr),
        .mask_wdata  (avs_writedata[5:0]),
        .status_reg  (irq_status),
        .mask_reg    (irq_mask),
        .irq_reg     (irq)
    );

    // Read mux; unmapped words read as zero
    always @* begin
        rd_mux = 16'h0000;
        if (hit(avs_address, `SDS_IDX_RX_A_START)) begin
            rd_mux = `SDS_START_FIXED | {3'b000, rx_a_start_address_reg}; // RL12
        end else if (hit(avs_address, `SDS_IDX_RX_A_POS)) begin
            rd_mux = {3'b000, rx_a_byte_offset}; // RL6
        end else if (hit(avs_address, `SDS_IDX_RX_B_POS)) begin
            rd_mux = {3'b000, rx_b_byte_offset}; // RL7
        end else if (hit(avs_address, `SDS_IDX_TX_POS)) begin
            rd_mux = {3'b000, tx_byte_offset_now}; // RL8
        end else if (hit(avs_address, `SDS_IDX_XFER_STATE)) begin
            rd_mux = xfer_state; // RL11
        end else if (hit(avs_address, `SDS_IDX_CTRL)) begin
            // Reset bits are write-only and always read zero
            rd_mux = {12'h000, tx_load_b_q, tx_load_a_q, rx_load_b_q, rx_load_a_q}; // RL13
        end else if (hit(avs_address, `SDS_IDX_INT_STATUS)) begin
            rd_mux = {10'h000, irq_status};
        end else if (hit(avs_address, `SDS_IDX_INT_MASK)) begin
            rd_mux = {10'h000, irq_mask};
        end else if (hit(avs_address, `SDS_IDX_BUF_LIMIT)) begin
            rd_mux = {3'b000, buf_limit_reg};
        end
    end

    always @* begin
        wr_image = 16'h0000;
        if (hit(avs_address, `SDS_IDX_RX_A_START)) begin
            wr_image = merge16({3'b000, rx_a_start_address_reg}, avs_writedata, avs_byteenable);
        end else if (hit(avs_address, `SDS_IDX_BUF_LIMIT)) begin
            wr_image = merge16({3'b000, buf_limit_reg}, avs_writedata, avs_byteenable);
        end
    end

    // Bus slave and writable registers
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            avs_waitrequest        <= 1'b1;
            avs_readdata           <= 32'h0000_0000;
            rx_a_start_address_reg <= `SDS_START_RST;
            buf_limit_reg          <= `SDS_LIMIT_RST;
        end else if (clk_en) begin
            avs_waitrequest <= ~acc_go;
            if (rd_go) begin
                avs_readdata <= {16'h0000, rd_mux};
            end
            if (wr_go && hit(avs_address, `SDS_IDX_RX_A_START)) begin
                rx_a_start_address_reg <= wr_image[12:0]; // RL10
            end
            if (wr_go && hit(avs_address, `SDS_IDX_BUF_LIMIT)) begin
                buf_limit_reg <= wr_image[12:0];
            end
        end
    end

    // Where the next byte goes; buffer A is offset from its start address
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rx_byte_addr   <= `SDS_START_RST;
            rx_byte_buf_b  <= 1'b0;
            tx_byte_offset <= `SDS_OFF_RST;
            tx_byte_buf_b  <= 1'b0;
        end else if (clk_en) begin
            // Wraps within 13 bits like the start field itself
            if (rx_cur_b_next) begin
                rx_byte_addr <= rx_off_next;
            end else begin
                rx_byte_addr <= rx_a_start_address_reg + rx_off_next; // RL10
            end
            rx_byte_buf_b  <= rx_cur_b_next;
            tx_byte_offset <= tx_off_next; // RL8
            tx_byte_buf_b  <= tx_cur_b_next;
        end
    end
endmodule // sds_top

// ### inc/sds_consts.vh
// Register map, field positions and reset values of the DMA status block
`ifndef SDS_CONSTS_VH
`define SDS_CONSTS_VH

// Register indexes; the bus byte address is four times the index
`define SDS_IDX_RX_A_START   15'h4400
`define SDS_IDX_RX_A_POS     15'h4410
`define SDS_IDX_RX_B_POS     15'h4412
`define SDS_IDX_TX_POS       15'h4414
`define SDS_IDX_XFER_STATE   15'h4416
`define SDS_IDX_CTRL         15'h4418
`define SDS_IDX_INT_STATUS   15'h4420
`define SDS_IDX_INT_MASK     15'h4422
`define SDS_IDX_BUF_LIMIT    15'h4424

// Transfer state fields
`define SDS_ST_RX_ACT_A      0
`define SDS_ST_RX_ACT_B      1
`define SDS_ST_TX_ACT_A      2
`define SDS_ST_TX_ACT_B      3
`define SDS_ST_RX_OVR_A      4
`define SDS_ST_RX_OVR_B      5

// Control fields
`define SDS_CT_RX_LOAD_A     0
`define SDS_CT_RX_LOAD_B     1
`define SDS_CT_TX_LOAD_A     2
`define SDS_CT_TX_LOAD_B     3
`define SDS_CT_RX_RST        4
`define SDS_CT_TX_RST        5

// Interrupt status and mask fields
`define SDS_IRQ_RX_DONE_A    0
`define SDS_IRQ_RX_DONE_B    1
`define SDS_IRQ_TX_DONE_A    2
`define SDS_IRQ_TX_DONE_B    3
`define SDS_IRQ_RX_OVR_A     4
`define SDS_IRQ_RX_OVR_B     5

// Widths and reset values
`define SDS_OFF_W            13
`define SDS_IRQ_W            6
`define SDS_START_FIXED      16'h6000
`define SDS_START_RST        13'h0000
`define SDS_LIMIT_RST        13'h1FFF
`define SDS_OFF_RST          13'h0000
`define SDS_MASK_RST         6'h00

`endif

// ### testbench/sds_fifo_model.sv
// Byte FIFO stand-in on the far side of both byte streams
`timescale 1ns/10ps
module sds_fifo_model (
    // Clock and reset
    input  logic core_clk,
    input  logic rst_n,
    // Byte streams
    input  logic rx_byte_ready,
    input  logic tx_byte_ready,
    output logic rx_byte_valid,
    output logic rx_byte_overrun,
    output logic tx_byte_take,
    // Status
    output logic idle
);
    int   rx_in = 0;
    int   tx_in = 0;
    int   rx_out;
    int   tx_out;
    int   rx_rem;
    logic mark = 1'b0;
    logic nv;
    assign idle = rx_in == rx_out && tx_in == tx_out;
    // Only push writes these, so it never races the clocked update
    task automatic push(input int rx_n, input int tx_n, input logic ovr);
        rx_in += rx_n;
        tx_in += tx_n;
        mark = ovr;
    endtask
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rx_out          <= 0;
            tx_out          <= 0;
            rx_byte_valid   <= 1'b0;
            rx_byte_overrun <= 1'b0;
            tx_byte_take    <= 1'b0;
        end else begin
            rx_rem = rx_in - rx_out - int'(rx_byte_valid && rx_byte_ready);
            rx_out <= rx_out + int'(rx_byte_valid && rx_byte_ready);
            tx_out <= tx_out + int'(tx_byte_take && tx_byte_ready);
            // A byte offered stays up until taken, as a full FIFO would
            nv = (rx_byte_valid && !rx_byte_ready) || (rx_rem > 0 && $urandom_range(3) != 0);
            rx_byte_valid   <= nv;
            rx_byte_overrun <= nv ? mark : !rx_byte_overrun;
            tx_byte_take    <= tx_in - tx_out > int'(tx_byte_take && tx_byte_ready)
                               && $urandom_range(3) != 0;
        end
    end
endmodule // sds_fifo_model

// ### testbench/sds_top_properties.sv
// Port assertions of the DMA status block
`timescale 1ns/10ps
module sds_top_properties (
    // Clock and reset
    input logic        core_clk,
    input logic        rst_n,
    input logic        clk_en,
    // Register bus
    input logic [16:0] avs_address,
    input logic        avs_read,
    input logic        avs_write,
    input logic [31:0] avs_readdata,
    input logic        avs_waitrequest,
    // Byte streams and interrupt
    input logic        rx_byte_valid,
    input logic        rx_byte_ready,
    input logic [12:0] rx_byte_addr,
    input logic        rx_byte_buf_b,
    input logic        tx_byte_take,
    input logic        tx_byte_ready,
    input logic [12:0] tx_byte_offset,
    input logic        tx_byte_buf_b,
    input logic        irq
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    a_wait_one: assert property (
        (avs_read || avs_write) && avs_waitrequest && clk_en |=> !avs_waitrequest)
        else $error("no answer after one wait");
    a_start_fixed: assert property (
        avs_read && !avs_waitrequest && avs_address[16:2] == 15'h4400
        |-> avs_readdata[15:13] == 3'b011)
        else $error("start fixed bits");
    a_rx_a_step: assert property (
        rx_byte_valid && rx_byte_ready && !rx_byte_buf_b && !avs_write
        ##1 rx_byte_ready && !rx_byte_buf_b && !avs_write
        |-> rx_byte_addr == $past(rx_byte_addr) + 13'h0001)
        else $error("rx A step");
    a_rx_b_step: assert property (
        rx_byte_valid && rx_byte_ready && rx_byte_buf_b && !avs_write
        ##1 rx_byte_ready && rx_byte_buf_b && !avs_write
        |-> rx_byte_addr == $past(rx_byte_addr) + 13'h0001)
        else $error("rx B step");
    a_tx_step: assert property (
        tx_byte_take && tx_byte_ready && !avs_write
        ##1 tx_byte_ready && $stable(tx_byte_buf_b) && !avs_write
        |-> tx_byte_offset == $past(tx_byte_offset) + 13'h0001)
        else $error("tx step");
    a_tx_wrap_zero: assert property (
        tx_byte_take && tx_byte_ready && !avs_write ##1 !tx_byte_ready
        |-> tx_byte_offset == 13'h0000)
        else $error("tx not zero after unload");
    a_ready_needs_load: assert property (
        $rose(rx_byte_ready) |-> $past(avs_write))
        else $error("rx ready rose unloaded");
    a_irq_cause: assert property (
        $rose(irq) |-> $past(rx_byte_valid) || $past(tx_byte_take) || $past(avs_write))
        else $error("irq rose without cause");
endmodule // sds_top_properties

bind sds_top sds_top_properties i_sds_top_properties (.*);

// ### testbench/sds_top_test.sv
// Self-checking bench for the DMA status and position block
`timescale 1ns/10ps
`include "sds_consts.vh"
module sds_top_test;
    localparam int DEPTH = 4;
    logic        core_clk = 1'b0;
    logic        rst_n = 1'b0;
    logic [16:0] avs_address = 17'h00000;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h00000000;
    wire  [31:0] avs_readdata;
    wire         avs_waitrequest;
    wire         rx_byte_valid;
    wire         rx_byte_overrun;
    wire         rx_byte_ready;
    wire  [12:0] rx_byte_addr;
    wire         rx_byte_buf_b;
    wire         tx_byte_take;
    wire         tx_byte_ready;
    wire  [12:0] tx_byte_offset;
    wire         tx_byte_buf_b;
    wire         irq;
    wire         idle;
    int          miscompares = 0;
    int          checks_done = 0;
    int          cycles = 0;
    int          n;
    logic [12:0] start;
    logic [14:0] ro_idx [5] = '{`SDS_IDX_RX_A_POS, `SDS_IDX_RX_B_POS, `SDS_IDX_TX_POS,
                                `SDS_IDX_XFER_STATE, 15'h4401};

    always #5 core_clk = ~core_clk;

    sds_top i_sds_top (.*, .clk_en(1'b1), .avs_byteenable(4'hF));

    sds_fifo_model i_sds_fifo_model (.*);

    task automatic end_sim;
        if (miscompares == 0 && checks_done > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected %0t %h %h", $time, seen, exp);
        end
    endtask

    task automatic bus(input logic wr, input logic [14:0] idx, input logic [31:0] wd,
                       output logic [31:0] data);
        avs_address   <= {idx, 2'b00};
        avs_writedata <= wd;
        avs_write     <= wr;
        avs_read      <= !wr;
        @(posedge core_clk);
        while (avs_waitrequest !== 1'b0)
            @(posedge core_clk);
        data = avs_readdata;
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
        @(posedge core_clk);
    endtask

    task automatic reg_write(input logic [14:0] idx, input logic [31:0] wd);
        logic [31:0] unused;
        bus(1'b1, idx, wd, unused);
    endtask

    task automatic reg_check(input logic [14:0] idx, input logic [31:0] exp);
        logic [31:0] data;
        bus(1'b0, idx, 32'h00000000, data);
        check(data, exp);
    endtask

    // Outputs lag the last byte
    task automatic settle;
        @(posedge core_clk);
        while (idle !== 1'b1)
            @(posedge core_clk);
        repeat (2) @(posedge core_clk);
    endtask

    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            miscompares++;
            end_sim();
        end
    end

    initial begin
        void'($urandom(97));
        repeat (4) @(posedge core_clk);
        rst_n <= 1'b1;
        @(posedge core_clk);
        reg_check(`SDS_IDX_RX_A_START, 32'h00006000);
        foreach (ro_idx[i])
            reg_check(ro_idx[i], 32'h00000000);
        start = 13'($urandom);
        reg_write(`SDS_IDX_RX_A_START, {19'h7FFFF, start});
        reg_check(`SDS_IDX_RX_A_START, {19'h00003, start});
        reg_write(`SDS_IDX_BUF_LIMIT, 32'(DEPTH - 1));
        reg_write(`SDS_IDX_CTRL, 32'h00000003);
        check({19'h00000, rx_byte_addr}, {19'h00000, start});
        n = DEPTH + 1 + $urandom_range(2);
        i_sds_fifo_model.push(n, 0, 1'b0);
        settle();
        reg_check(`SDS_IDX_RX_A_POS, 32'h00000000);
        reg_check(`SDS_IDX_RX_B_POS, 32'(n - DEPTH));
        reg_check(`SDS_IDX_XFER_STATE, 32'h00000002);
        check({19'h00000, rx_byte_addr}, 32'(n - DEPTH));
        i_sds_fifo_model.push(2 * DEPTH - n, 0, 1'b0);
        settle();
        reg_check(`SDS_IDX_RX_B_POS, 32'h00000000);
        reg_write(`SDS_IDX_CTRL, 32'h0000000C);
        i_sds_fifo_model.push(0, n, 1'b0);
        settle();
        reg_check(`SDS_IDX_TX_POS, 32'(n - DEPTH));
        reg_check(`SDS_IDX_XFER_STATE, 32'h00000008);
        check({31'h0, tx_byte_buf_b}, 32'h00000001);
        i_sds_fifo_model.push(0, 2 * DEPTH - n, 1'b0);
        settle();
        reg_check(`SDS_IDX_TX_POS, 32'h00000000);
        reg_check(`SDS_IDX_XFER_STATE, 32'h00000000);
        reg_check(`SDS_IDX_INT_STATUS, 32'h0000000F);
        for (int b = 0; b < 2; b++) begin
            reg_write(`SDS_IDX_INT_MASK, b ? 32'h00000020 : 32'h00000000);
            reg_write(`SDS_IDX_CTRL, 32'h00000010);
            // Both buffers unloaded: the marked byte waits in the FIFO
            i_sds_fifo_model.push(1, 0, 1'b1);
            repeat (4) @(posedge core_clk);
            reg_check(`SDS_IDX_XFER_STATE, 32'h00000000);
            reg_write(`SDS_IDX_CTRL, 32'(1 << b));
            settle();
            reg_check(`SDS_IDX_XFER_STATE, 32'(17 << b));
            check({19'h00000, rx_byte_addr}, b ? 32'h1 : {19'h0, start + 13'h0001});
            check({31'h0, irq}, 32'(b));
            reg_check(`SDS_IDX_INT_STATUS, 32'(16 << b));
            check({31'h0, irq}, 32'h00000000);
            reg_write(`SDS_IDX_CTRL, 32'(1 << b));
            reg_check(`SDS_IDX_XFER_STATE, 32'(1 << b));
        end
        reg_write(`SDS_IDX_CTRL, 32'h00000010);
        reg_check(`SDS_IDX_RX_B_POS, 32'h00000000);
        reg_check(`SDS_IDX_XFER_STATE, 32'h00000000);
        end_sim();
    end
endmodule // sds_top_test
